// File: core/tsls_top.sv
`timescale 1ns/1ns
module tsls_top import tsls_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// probe pins
	input wire logic [POD_NUM*POD_W-1:0] probe_in,
	input wire logic mclk_pin,
	input wire logic lclk_pin,
	input wire logic mclk_unused_pin,
	input wire logic nclk_pin,
	// slave clock setup per pod, two bits each
	input wire logic [POD_NUM*2-1:0] sck_mode,
	input wire logic [POD_NUM*2-1:0] sck_edge,
	input wire logic [POD_NUM*2-1:0] sck_src,
	// analyzer control
	input wire logic init,
	input wire logic cfg_complex,
	input wire logic trace_start,
	input wire logic trace_halt,
	// sequencer command
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [3:0] cmd_idx,
	input wire logic cur_secondary,
	output logic cmd_reject,
	// trace stream
	output logic [POD_NUM*POD_W-1:0] trace_data,
	output logic trace_valid,
	output logic trace_store,
	output logic trigger,
	// status
	output logic running,
	output logic triggered,
	output logic cplx_active,
	output logic [3:0] seq_term,
	output logic [3:0] term_count,
	output logic [3:0] trig_term
);
	// ***************************************
	// state
	// ***************************************
	typedef struct packed {
		logic cplx;
		logic run;
		logic trigd;
		logic [3:0] term;
		logic [3:0] cnt;
		logic [3:0] trig;
		logic [TERM_MAX-1:0] prim;
		logic [TERM_MAX-1:0] sec;
		logic [TERM_MAX-1:0] stor;
		logic [POD_NUM*2-1:0] mode;
		logic [POD_NUM*2-1:0] edg;
		logic [POD_NUM*2-1:0] src;
		logic vld;
		logic trg_p;
		logic sto;
		logic rej;
		logic mprev;
	} tsls_st_t;
	tsls_st_t s_q, s_d;

	// ***************************************
	// pin synchronisers
	// ***************************************
	logic [POD_NUM*POD_W-1:0] probe_s;
	logic [3:0] clk_s;
	logic mstr_edge;
	tsls_sync #(.W(POD_NUM*POD_W)) u_sync_probe (
		.clk(clk),
		.rst(rst),
		.d(probe_in),
		.q(probe_s)
	);
	tsls_sync #(.W(4)) u_sync_clk (
		.clk(clk),
		.rst(rst),
		.d({nclk_pin, mclk_unused_pin, lclk_pin, mclk_pin}),
		.q(clk_s)
	);
	// master capture on the rising edge of the synchronised master clock
	assign mstr_edge = clk_s[0] & ~s_q.mprev;

	// ***************************************
	// pods
	// ***************************************
	for (genvar p = 0; p < POD_NUM; p++) begin : g_pod
		logic sclk_sel;
		// second source has no function and never toggles
		always_comb begin
			unique case (s_q.src[2*p +: 2])
				SRC_L: sclk_sel = clk_s[1];
				SRC_N: sclk_sel = clk_s[3];
				default: sclk_sel = 1'b0;
			endcase
		end
		tsls_pod u_pod (
			.clk(clk),
			.rst(rst),
			.din(probe_s[POD_W*p +: POD_W]),
			.sclk(sclk_sel),
			.mstr_edge(mstr_edge),
			.mode(s_q.mode[2*p +: 2]),
			.edge_sel(s_q.edg[2*p +: 2]),
			.dout(trace_data[POD_W*p +: POD_W])
		);
	end

	// ***************************************
	// term list helpers
	// ***************************************
	function automatic logic [TERM_MAX-1:0] ins_bit(input logic [TERM_MAX-1:0] v, input logic [2:0] x,
		input logic b);
		logic [TERM_MAX-1:0] up;
		logic [TERM_MAX-1:0] r;
		up = {v[TERM_MAX-2:0], 1'b0};
		for (int i = 0; i < TERM_MAX; i++) begin
			r[i] = (3'(i) < x) ? v[i] : (3'(i) == x) ? b : up[i];
		end
		return r;
	endfunction
	function automatic logic [TERM_MAX-1:0] del_bit(input logic [TERM_MAX-1:0] v, input logic [2:0] x);
		logic [TERM_MAX-1:0] dn;
		logic [TERM_MAX-1:0] r;
		dn = {1'b0, v[TERM_MAX-1:1]};
		for (int i = 0; i < TERM_MAX; i++) begin
			r[i] = (3'(i) < x) ? v[i] : dn[i];
		end
		return r;
	endfunction

	// ***************************************
	// sequencer and setup
	// ***************************************
	logic [3:0] xm1;
	logic [3:0] nxt;
	logic ins_ok, del_ok, trg_ok, seq_rst;
	assign xm1 = cmd_idx - 4'h1;
	assign nxt = s_q.term + 4'h1;
	// contiguous insert within 1..4, delete keeps at least one term
	assign ins_ok = !s_q.cplx && cmd_idx >= FIRST_TERM && cmd_idx <= EASY_MAX_TERMS
		&& cmd_idx <= s_q.cnt + 4'h1 && s_q.cnt < EASY_MAX_TERMS;
	assign del_ok = !s_q.cplx && cmd_idx >= FIRST_TERM && cmd_idx <= s_q.cnt && s_q.cnt > FIRST_TERM;
	assign trg_ok = s_q.cplx && cmd_idx >= CPLX_TRIG_MIN && cmd_idx <= CPLX_TERMS;
	// a configuration change waits for an idle analyzer
	assign seq_rst = !s_q.run && (cfg_complex != s_q.cplx
		|| (cmd_valid && cmd_op == SEQ_RESET));

	always_comb begin
		s_d = s_q;
		s_d.mprev = clk_s[0];
		s_d.vld = mstr_edge;
		s_d.trg_p = 1'b0;
		s_d.rej = 1'b0;
		s_d.sto = 1'b0;
		// trace run control; pod setup is copied only at start
		if (trace_start && !s_q.run) begin
			s_d.run = 1'b1;
			s_d.trigd = 1'b0;
			s_d.term = FIRST_TERM;
			s_d.mode = sck_mode;
			s_d.edg = sck_edge;
			s_d.src = sck_src;
		end else if (trace_halt) begin
			s_d.run = 1'b0;
		end
		// stepping on each captured state
		if (s_q.vld && s_q.run) begin
			s_d.sto = s_q.stor[s_q.term[2:0] - 3'h1];
			if (!s_q.trigd) begin
				if (s_q.trig == FIRST_TERM) begin
					s_d.trg_p = 1'b1;
					s_d.trigd = 1'b1;
				end else if (s_q.prim[s_q.term[2:0] - 3'h1] && s_q.term < s_q.cnt) begin
					s_d.term = nxt;
					if (nxt == s_q.trig) begin
						s_d.trg_p = 1'b1;
						s_d.trigd = 1'b1;
					end
				end else if (s_q.sec[s_q.term[2:0] - 3'h1]) begin
					s_d.term = FIRST_TERM;
				end
			end
		end
		// commands are refused while tracing
		if (cmd_valid && s_q.run) begin
			s_d.rej = 1'b1;
		end else if (seq_rst) begin
			s_d.cplx = cfg_complex;
			s_d.sec = '0;
			s_d.stor = STORE_ALL;
			if (cfg_complex) begin
				s_d.cnt = CPLX_TERMS;
				s_d.trig = CPLX_RST_TRIG;
				s_d.prim = CPLX_RST_PRIM;
			end else begin
				s_d.cnt = EASY_RST_TERMS;
				s_d.trig = EASY_RST_TERMS;
				s_d.prim = '0;
			end
		end else if (cmd_valid) begin
			unique case (cmd_op)
				SEQ_INSERT: begin
					if (ins_ok) begin
						s_d.cnt = s_q.cnt + 4'h1;
						s_d.trig = s_q.cnt + 4'h1;
						s_d.prim = ins_bit(s_q.prim, xm1[2:0], cmd_idx <= s_q.cnt);
						s_d.sec = ins_bit(s_q.sec, xm1[2:0], cur_secondary);
						s_d.stor = ins_bit(s_q.stor, xm1[2:0], 1'b1);
					end else begin
						s_d.rej = 1'b1;
					end
				end
				SEQ_DELETE: begin
					if (del_ok) begin
						s_d.cnt = s_q.cnt - 4'h1;
						s_d.trig = s_q.cnt - 4'h1;
						s_d.prim = del_bit(s_q.prim, xm1[2:0]);
						s_d.sec = del_bit(s_q.sec, xm1[2:0]);
						s_d.stor = del_bit(s_q.stor, xm1[2:0]);
					end else begin
						s_d.rej = 1'b1;
					end
				end
				SEQ_TRIG: begin
					if (trg_ok) begin
						s_d.trig = cmd_idx;
					end else begin
						s_d.rej = 1'b1;
					end
				end
				default: s_d.rej = 1'b0;
			endcase
		end
		// analyzer initialisation wins over everything
		if (init) begin
			s_d = '0;
			s_d.cnt = INIT_TERMS;
			s_d.trig = INIT_TRIG;
			s_d.prim = INIT_PRIM;
			s_d.stor = STORE_ALL;
			s_d.mprev = clk_s[0];
		end
	end

	// registers; same values on reset as on init, except mprev, which init takes from the synchronised master clock
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.cnt <= INIT_TERMS;
			s_q.trig <= INIT_TRIG;
			s_q.prim <= INIT_PRIM;
			s_q.stor <= STORE_ALL;
		end else begin
			s_q <= s_d;
		end
	end

	// ***************************************
	// outputs
	// ***************************************
	assign trace_valid = s_q.vld;
	assign trace_store = s_q.sto;
	assign trigger = s_q.trg_p;
	assign cmd_reject = s_q.rej;
	assign running = s_q.run;
	assign triggered = s_q.trigd;
	assign cplx_active = s_q.cplx;
	assign seq_term = s_q.term;
	assign term_count = s_q.cnt;
	assign trig_term = s_q.trig;

	// ***************************************
	// checks
	// ***************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_REJ_RUN: assert property (cmd_valid && s_q.run && !init |=> cmd_reject)
		else $error("command taken while running");
	AST_INS_GAP: assert property (cmd_valid && !s_q.run && !seq_rst && !init && cmd_op == SEQ_INSERT
		&& cmd_idx > s_q.cnt + 4'h1 |=> cmd_reject && term_count == $past(term_count))
		else $error("gapped insert accepted");
	AST_CPLX_CNT: assert property (s_q.cplx |-> s_q.cnt == CPLX_TERMS)
		else $error("complex term count not eight");
	AST_EASY_CNT: assert property (!s_q.cplx |-> s_q.cnt >= 4'h1 && s_q.cnt <= 4'h4)
		else $error("easy term count out of range");
	AST_CPLX_TRIG: assert property (s_q.cplx |-> s_q.trig >= 4'h2 && s_q.trig <= 4'h8)
		else $error("complex trigger term out of range");
	AST_TRIG_ENTRY: assert property (trigger |-> seq_term == trig_term ##1 triggered)
		else $error("trigger outside trigger term");
	AST_CPLX_RST: assert property ($rose(s_q.cplx) |-> s_q.trig == 4'h2 && s_q.prim == 8'h7f && s_q.sec == 8'h00)
		else $error("complex reset values wrong");
	AST_INIT: assert property (init |=> term_count == 4'h2 && trig_term == 4'h2 && s_q.mode == '0 && !running)
		else $error("init defaults wrong");
	AST_EASY_RST: assert property (cmd_valid && cmd_op == SEQ_RESET && !s_q.run && !cfg_complex && !init
		|=> term_count == 4'h1 && trig_term == 4'h1)
		else $error("easy reset not single term");
	AST_DEL: assert property (cmd_valid && !s_q.run && cmd_op == SEQ_DELETE && del_ok && !seq_rst && !init
		|=> term_count == $past(term_count) - 4'h1)
		else $error("delete did not renumber");
	COV_TRIG: cover property (trace_start ##[1:200] trigger);
	COV_INS: cover property (cmd_valid && cmd_op == SEQ_INSERT && ins_ok);
	COV_CPLX: cover property ($rose(s_q.cplx));
endmodule // tsls_top

// File: core/tsls_pkg.sv
package tsls_pkg;
	// ***************************************
	// geometry
	// ***************************************
	localparam int POD_NUM = 5;
	localparam int POD_W = 16;
	localparam int BYTE_W = 8;
	localparam int TERM_MAX = 8;
	localparam logic [3:0] EASY_MAX_TERMS = 4'h4;
	localparam logic [3:0] CPLX_TERMS = 4'h8;
	localparam logic [3:0] CPLX_TRIG_MIN = 4'h2;
	// ***************************************
	// reset values
	// ***************************************
	localparam logic [3:0] INIT_TERMS = 4'h2;
	localparam logic [3:0] INIT_TRIG = 4'h2;
	localparam logic [7:0] INIT_PRIM = 8'h01;
	localparam logic [3:0] EASY_RST_TERMS = 4'h1;
	localparam logic [3:0] CPLX_RST_TRIG = 4'h2;
	localparam logic [7:0] CPLX_RST_PRIM = 8'h7f;
	localparam logic [7:0] STORE_ALL = 8'hff;
	localparam logic [3:0] FIRST_TERM = 4'h1;
	// ***************************************
	// encodings
	// ***************************************
	typedef enum logic [1:0] {SCK_OFF = 2'h0, SCK_DEMUX = 2'h1, SCK_MIX = 2'h3} tsls_mode_t;
	typedef enum logic [1:0] {EDG_RISE = 2'h1, EDG_FALL = 2'h2, EDG_BOTH = 2'h3} tsls_edge_t;
	typedef enum logic [1:0] {SRC_L = 2'h0, SRC_M = 2'h1, SRC_N = 2'h2} tsls_src_t;
	typedef enum logic [1:0] {SEQ_RESET = 2'h0, SEQ_INSERT = 2'h1, SEQ_DELETE = 2'h3, SEQ_TRIG = 2'h2} tsls_op_t;
endpackage

// File: core/tsls_sync.sv
`timescale 1ns/1ns
module tsls_sync import tsls_pkg::*; #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	// two flops; only the second one is looked at
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // tsls_sync

// File: core/tsls_pod.sv
`timescale 1ns/1ns
module tsls_pod import tsls_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// synchronised pod lines and clocks
	input wire logic [POD_W-1:0] din,
	input wire logic sclk,
	input wire logic mstr_edge,
	// active setup
	input wire logic [1:0] mode,
	input wire logic [1:0] edge_sel,
	// captured pod word
	output logic [POD_W-1:0] dout
);
	typedef struct packed {
		logic sprev;
		logic seen;
		logic [BYTE_W-1:0] sbyte;
		logic [POD_W-1:0] out;
	} tsls_pod_st_t;
	tsls_pod_st_t s_q, s_d;
	logic rise, fall, sedge;
	logic [BYTE_W-1:0] lo;
	// edge qualification
	assign rise = sclk & ~s_q.sprev;
	assign fall = ~sclk & s_q.sprev;
	assign sedge = (edge_sel[0] & rise) | (edge_sel[1] & fall);
	assign lo = din[BYTE_W-1:0];
	// latch and master capture; slave edge in the master cycle counts for the next sample
	always_comb begin
		s_d = s_q;
		s_d.sprev = sclk;
		if (mstr_edge) begin
			s_d.seen = 1'b0;
			unique case (mode)
				SCK_DEMUX: s_d.out = {s_q.sbyte, s_q.sbyte};
				SCK_MIX: s_d.out = {din[POD_W-1:BYTE_W], s_q.seen ? s_q.sbyte : lo};
				default: s_d.out = din;
			endcase
		end
		if (sedge && mode != SCK_OFF) begin
			if (mode == SCK_DEMUX || !s_q.seen || mstr_edge) begin
				s_d.sbyte = lo;
			end
			s_d.seen = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign dout = s_q.out;
	// checks
	AST_DEMUX_DUP: assert property (@(posedge clk) disable iff (rst)
		mstr_edge && mode == SCK_DEMUX |=> dout[POD_W-1:BYTE_W] == dout[BYTE_W-1:0])
		else $error("demux pod halves differ");
	AST_OFF_RAW: assert property (@(posedge clk) disable iff (rst)
		mstr_edge && mode == SCK_OFF |=> dout == $past(din))
		else $error("off pod not master sampled");
	AST_MIX_HOLD: assert property (@(posedge clk) disable iff (rst)
		s_q.seen && !mstr_edge && mode == SCK_MIX |=> s_q.sbyte == $past(s_q.sbyte))
		else $error("mixed pod overwrote first slave byte");
	COV_DEMUX: cover property (@(posedge clk) disable iff (rst) sedge && mode == SCK_DEMUX ##[1:20] mstr_edge);
endmodule // tsls_pod

// File: testbench/tsls_probe_model.sv
`timescale 1ns/1ns
module tsls_probe_model import tsls_pkg::*; (
	// pacing clock
	input wire logic clk,
	// probe pins toward the block
	output logic [POD_NUM*POD_W-1:0] probe_in,
	output logic mclk_pin,
	output logic lclk_pin,
	output logic mclk_unused_pin,
	output logic nclk_pin
);
	// ****************************
	// probed bus drivers
	// ****************************
	// link clocks idle low, they only move when tog is called
	initial begin
		probe_in = '0;
		mclk_pin = 1'b0;
		lclk_pin = 1'b0;
		mclk_unused_pin = 1'b0;
		nclk_pin = 1'b0;
	end
	// half of a 160 ns link period, so the block's sampler sees every level
	task automatic hold();
		repeat (4) @(negedge clk);
	endtask
	// new bus word, held long enough to be latched
	task automatic put(input logic [POD_NUM*POD_W-1:0] v);
		@(negedge clk);
		probe_in = v;
		hold();
	endtask
	// one edge on a clock line: 0 L, 1 M, 2 N, else master
	task automatic tog(input int k);
		@(negedge clk);
		case (k)
			0: lclk_pin = ~lclk_pin;
			1: mclk_unused_pin = ~mclk_unused_pin;
			2: nclk_pin = ~nclk_pin;
			default: mclk_pin = ~mclk_pin;
		endcase
		hold();
	endtask
endmodule // tsls_probe_model

// File: testbench/trace_slave_latch_and_sequencer_test.sv
`timescale 1ns/1ns
module trace_slave_latch_and_sequencer_test import tsls_pkg::*;;
	logic clk, rst, mclk_pin, lclk_pin, mclk_unused_pin, nclk_pin, init, cfg_complex, trace_start, trace_halt;
	logic cmd_valid, cur_secondary, cmd_reject, trace_valid, trace_store, trigger, running, triggered, cplx_active;
	logic [79:0] probe_in, trace_data, cap_data, d0, d1, d2, d3;
	logic [9:0] sck_mode, sck_edge, sck_src;
	logic [1:0] cmd_op, op;
	logic [3:0] cmd_idx, seq_term, term_count, trig_term;
	logic [31:0] seed;
	logic prev_valid, trig_lag, rej, xr;
	int failures = 0, check_count = 0, cyc = 0, vn = 0, sn = 0, tn = 0, cnt, t0;

	tsls_top i_dut (.clk, .rst, .probe_in, .mclk_pin, .lclk_pin, .mclk_unused_pin, .nclk_pin, .sck_mode, .sck_edge,
		.sck_src, .init, .cfg_complex, .trace_start, .trace_halt, .cmd_valid, .cmd_op, .cmd_idx, .cur_secondary,
		.cmd_reject, .trace_data, .trace_valid, .trace_store, .trigger, .running, .triggered, .cplx_active, .seq_term,
		.term_count, .trig_term);
	tsls_probe_model i_bus (.clk, .probe_in, .mclk_pin, .lclk_pin, .mclk_unused_pin, .nclk_pin);

	// ****************************
	// helpers
	// ****************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	function automatic logic [79:0] rnd80();
		logic [79:0] r;
		r = '0;
		repeat (3) begin
			seed = lfsr(seed);
			r = {r[47:0], seed};
		end
		return r;
	endfunction
	// pods: 0 off, 1 demux rise L, 2 mixed rise L, 3 demux fall N, 4 mixed any edge M
	function automatic logic [79:0] exp_frame(input logic [79:0] f, m, x);
		return {f[79:64], {2{x[55:48]}}, f[47:40], m[39:32], {2{x[23:16]}}, f[15:0]};
	endfunction
	function automatic logic exp_rej(input logic [1:0] o, input int x, n);
		if (o == SEQ_INSERT) return !(x >= 1 && x <= n + 1 && n < 4);
		return !(x >= 1 && x <= n && n > 1);
	endfunction
	task automatic chk_data(input logic [79:0] got, exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_stat(input logic [3:0] got, exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	// reject pulse is registered on the edge that takes the command and lasts one cycle, so the first of the two looks sees it
	task automatic cmd(input logic [1:0] o, input logic [3:0] x);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_idx = x;
		cur_secondary = seed[0];
		@(negedge clk);
		cmd_valid = 1'b0;
		rej = cmd_reject;
		@(negedge clk);
		rej = rej | cmd_reject;
		@(negedge clk);
	endtask
	// master pulse, then the captured word and one valid strobe
	task automatic frame(input logic [79:0] exp);
		int v0;
		v0 = vn;
		i_bus.tog(3);
		repeat (8) @(negedge clk);
		i_bus.tog(3);
		chk_stat(4'(vn - v0), 4'h1);
		chk_data(cap_data, exp);
	endtask
	// stream watcher and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		prev_valid <= trace_valid;
		if (trace_valid) begin
			vn <= vn + 1;
			cap_data <= trace_data;
		end
		if (trace_store) sn <= sn + 1;
		if (trigger) begin
			tn <= tn + 1;
			trig_lag <= prev_valid;
		end
		if (cyc == 6000) begin
			failures++;
			end_sim();
		end
	end

	// ****************************
	// scenarios
	// ****************************
	initial begin
		seed = 32'hefcf1890;
		d0 = rnd80();
		// init and start wander during reset, which must win over both
		{rst, init, cfg_complex, trace_start, trace_halt, cmd_valid, cur_secondary} = {1'b1, d0[0], 1'b0, d0[1], 3'h0};
		{cmd_op, cmd_idx} = 6'h00;
		sck_mode = {SCK_MIX, SCK_DEMUX, SCK_MIX, SCK_DEMUX, SCK_OFF};
		// edge and source of the off pod and edge of the dead-source pod are don't cares
		sck_edge = {d0[3:2], EDG_FALL, EDG_RISE, EDG_RISE, d0[5:4]};
		sck_src = {SRC_M, SRC_N, SRC_L, SRC_L, d0[7:6]};
		repeat (3) @(negedge clk);
		{rst, init, trace_start} = 3'h0;
		chk_stat({3'h0, running}, 4'h0);
		chk_stat(term_count, INIT_TERMS);
		chk_stat(trig_term, INIT_TRIG);
		d0 = rnd80();
		d1 = rnd80();
		d2 = rnd80();
		d3 = rnd80();
		pulse(trace_start);
		chk_stat({3'h0, running}, 4'h1);
		i_bus.put(d0);
		i_bus.tog(0);
		i_bus.tog(2);
		i_bus.tog(1);
		i_bus.put(d1);
		i_bus.tog(2);
		i_bus.tog(0);
		i_bus.tog(1);
		i_bus.tog(0);
		i_bus.put(d2);
		i_bus.tog(0);
		frame(exp_frame(d2, d0, d1));
		chk_stat(4'(tn), 4'h1);
		chk_stat({2'h0, trig_lag, triggered}, 4'h3);
		chk_stat(4'(sn), 4'h1);
		i_bus.put(d3);
		frame(exp_frame(d3, d3, d1));
		cmd(SEQ_RESET, 4'h0);
		chk_stat({3'h0, rej}, 4'h1);
		pulse(trace_halt);
		$display("test pods done");
		cmd(SEQ_RESET, 4'h0);
		chk_stat(term_count, EASY_RST_TERMS);
		cnt = 1;
		repeat (30) begin
			seed = lfsr(seed);
			op = seed[8] ? SEQ_DELETE : SEQ_INSERT;
			cmd(op, {1'b0, seed[2:0]});
			xr = exp_rej(op, int'(seed[2:0]), cnt);
			chk_stat({3'h0, rej}, {3'h0, xr});
			if (!xr) cnt += (op == SEQ_INSERT) ? 1 : -1;
			chk_stat(term_count, 4'(cnt));
			chk_stat(trig_term, 4'(cnt));
		end
		repeat (5) cmd(SEQ_INSERT, 4'h1);
		chk_stat({rej, term_count[2:0]}, 4'hc);
		repeat (4) cmd(SEQ_DELETE, 4'h1);
		chk_stat({rej, term_count[2:0]}, 4'h9);
		cmd(SEQ_TRIG, 4'h2);
		chk_stat({3'h0, rej}, 4'h1);
		$display("test easy done");
		cfg_complex = 1'b1;
		repeat (3) @(negedge clk);
		chk_stat(term_count, CPLX_TERMS);
		chk_stat({cplx_active, trig_term[2:0]}, 4'ha);
		for (int i = 0; i < 10; i++) begin
			cmd(SEQ_TRIG, 4'(i));
			chk_stat({3'h0, rej}, (i >= 2 && i <= 8) ? 4'h0 : 4'h1);
		end
		chk_stat(trig_term, 4'h8);
		cmd(SEQ_INSERT, 4'h1);
		chk_stat({rej, term_count[2:0]}, 4'h8);
		// every pod gets code 0 or the unused code 2, both of which mean off
		sck_mode = d3[9:0] & 10'h2aa;
		cmd(SEQ_TRIG, 4'h3);
		pulse(trace_start);
		t0 = tn;
		i_bus.put(d1);
		frame(d1);
		chk_stat(4'(tn - t0), 4'h0);
		i_bus.put(d2);
		frame(d2);
		chk_stat(4'(tn - t0), 4'h1);
		chk_stat(seq_term, 4'h3);
		pulse(trace_halt);
		$display("test complex done");
		cfg_complex = 1'b0;
		pulse(init);
		chk_stat(term_count, INIT_TERMS);
		chk_stat({cplx_active, trig_term[2:0]}, 4'h2);
		$display("test init done");
		end_sim();
	end
endmodule // trace_slave_latch_and_sequencer_test
